/* hw/sxr_pending.v */
// Sticky pending flag for a soft-restart request
`timescale 1ns/1ps

module sxr_pending (
    // Clock and reset
    input  wire core_clk_in,
    input  wire resetn_in,
    // Control
    input  wire set_in,
    input  wire clear_in,
    // Status
    output reg  pending_out
);

// ----------------------------------------
// Flag
// ----------------------------------------
// A new request in the clearing cycle must survive, so set wins
always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
        pending_out <= 1'b0;
    end else if (set_in) begin
        pending_out <= 1'b1;
    end else if (clear_in) begin
        pending_out <= 1'b0;
    end
end

endmodule // sxr_pending

/* hw/sxr_unit.v */
// Soft-restart redirect into the security exception
// Behaviour
// - The security exception is raised only to redirect an external soft-restart request.
// - A request is redirected only when the redirect enable is set, else it restarts normally.
// - While the global interrupt flag is zero a request is held pending and not acted on.
// - When the flag becomes one with a request pending, restart or redirect per current enable.
// - The security exception dispatches through vector thirty.
// - The security exception is delivered as a fault, like the general protection fault.
// - An error code of one is pushed, meaning a soft-restart was redirected.
// - The security exception counts as a contributory fault for double-fault escalation.
// - A startup message in secure mode clears the flag and sets redirect enable and two flags.
`timescale 1ns/1ps
`include "sxr_regs.vh"

module sxr_unit (
    // Clock and reset
    input  wire        core_clk_in,
    input  wire        resetn_in,
    // External soft-restart request, one-cycle pulse or level
    input  wire        restart_req_in,
    // Global interrupt flag control from the core
    input  wire        global_interrupt_flag_set_in,
    input  wire        global_interrupt_flag_clr_in,
    // Control register writes from the core
    input  wire        ctl_wr_in,
    input  wire [2:0]  ctl_wdata_in,
    // Secure startup message
    input  wire        startup_msg_in,
    input  wire        secure_boot_in,
    // Core accepted the delivered event
    input  wire        deliver_ack_in,
    // State
    output reg         global_interrupt_flag_out,
    output reg  [2:0]  ctl_out,
    output reg         pending_out,
    // Delivery toward the core
    output reg         restart_out,
    output reg         exc_valid_out,
    output reg  [7:0]  exc_vector_out,
    output reg  [31:0] exc_err_code_out,
    output reg         exc_has_err_out,
    output reg         exc_is_fault_out,
    output reg  [1:0]  exc_class_out
);

// ----------------------------------------
// States
// ----------------------------------------
localparam ST_IDLE  = 2'h0;
localparam ST_EXC   = 2'h1;
localparam ST_RST   = 2'h2;

reg  [1:0] state;
reg  [1:0] next_state;
wire       req_pending;
wire       startup_hit;
wire       dispatch;
wire       delivered;
wire       offer_exc;
wire       offer_rst;

assign startup_hit = startup_msg_in & secure_boot_in;
// Nothing is dispatched while the flag is zero or a delivery is open
assign dispatch    = req_pending & global_interrupt_flag_out & (state == ST_IDLE);
assign delivered   = deliver_ack_in & (state != ST_IDLE);
assign offer_exc   = (next_state == ST_EXC);
assign offer_rst   = (next_state == ST_RST);

// ----------------------------------------
// Pending request
// ----------------------------------------
sxr_pending sxr_pending_inst (
    .core_clk_in (core_clk_in),
    .resetn_in   (resetn_in),
    .set_in      (restart_req_in),
    .clear_in    (delivered),
    .pending_out (req_pending)
);

// ----------------------------------------
// Global interrupt flag
// ----------------------------------------
// Set wins over clear when the core pulses both in one cycle
always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
        global_interrupt_flag_out <= 1'b1;
    end else if (startup_hit) begin
        global_interrupt_flag_out <= 1'b0;
    end else if (global_interrupt_flag_set_in) begin
        global_interrupt_flag_out <= 1'b1;
    end else if (global_interrupt_flag_clr_in) begin
        global_interrupt_flag_out <= 1'b0;
    end
end

// ----------------------------------------
// Control bits
// ----------------------------------------
// A secure startup message overrides a write in the same cycle
wire [2:0] next_ctl;
genvar     ctl_bit;

generate
    for (ctl_bit = 0; ctl_bit < `SXR_CTL_W; ctl_bit = ctl_bit + 1) begin : g_ctl
        assign next_ctl[ctl_bit] = startup_hit ? 1'b1 :
                                   ctl_wr_in   ? ctl_wdata_in[ctl_bit] :
                                                 ctl_out[ctl_bit];
    end
endgenerate

always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
        ctl_out <= `SXR_CTL_RESET;
    end else begin
        ctl_out <= next_ctl;
    end
end

// ----------------------------------------
// Dispatch
// ----------------------------------------
always @* begin
    next_state = state;
    case (state)
        ST_IDLE: begin
            if (dispatch) begin
                // Enable is sampled at dispatch, not at request time
                if (ctl_out[`SXR_CTL_REDIRECT]) begin
                    next_state = ST_EXC;
                end else begin
                    next_state = ST_RST;
                end
            end
        end
        ST_EXC, ST_RST: begin
            if (deliver_ack_in) begin
                next_state = ST_IDLE;
            end
        end
        default: next_state = ST_IDLE;
    endcase
end

// ----------------------------------------
// Delivery registers
// ----------------------------------------
// Each output has a flop of its own, so every pin comes straight from a register
always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
        state <= ST_IDLE;
    end else begin
        state <= next_state;
    end
end

// Status copy lags the internal flag by one cycle
always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
        pending_out <= 1'b0;
    end else begin
        pending_out <= req_pending;
    end
end

always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
        restart_out <= 1'b0;
    end else begin
        restart_out <= offer_rst;
    end
end

// Only a redirected restart ever raises this exception
always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
        exc_valid_out <= 1'b0;
    end else begin
        exc_valid_out <= offer_exc;
    end
end

always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
        exc_vector_out <= 8'h00;
    end else if (offer_exc) begin
        exc_vector_out <= `SXR_VECTOR;
    end else begin
        exc_vector_out <= 8'h00;
    end
end

always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
        exc_err_code_out <= 32'h00000000;
    end else if (offer_exc) begin
        exc_err_code_out <= `SXR_ERR_CODE;
    end else begin
        exc_err_code_out <= 32'h00000000;
    end
end

always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
        exc_has_err_out <= 1'b0;
    end else if (offer_exc) begin
        exc_has_err_out <= 1'b1;
    end else begin
        exc_has_err_out <= 1'b0;
    end
end

always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
        exc_is_fault_out <= 1'b0;
    end else if (offer_exc) begin
        exc_is_fault_out <= 1'b1;
    end else begin
        exc_is_fault_out <= 1'b0;
    end
end

// The class feeds double-fault escalation in the core
always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
        exc_class_out <= `SXR_CLASS_BENIGN;
    end else if (offer_exc) begin
        exc_class_out <= `SXR_CLASS_CONTRIB;
    end else begin
        exc_class_out <= `SXR_CLASS_BENIGN;
    end
end

endmodule // sxr_unit

/* pkg/sxr_regs.vh */
// Constants of the soft-restart redirect exception unit
`ifndef SXR_REGS_VH
`define SXR_REGS_VH

// ----------------------------------------
// Exception encoding
// ----------------------------------------
`define SXR_VECTOR          8'h1e
`define SXR_ERR_CODE        32'h00000001
`define SXR_CLASS_CONTRIB   2'h1
`define SXR_CLASS_BENIGN    2'h0

// ----------------------------------------
// Control flag positions set by a secure startup message
// ----------------------------------------
`define SXR_CTL_DEBUG_OFF   0
`define SXR_CTL_REDIRECT    1
`define SXR_CTL_A20_OFF     2
`define SXR_CTL_W           3
`define SXR_CTL_RESET       3'h0

`endif

/* testbench/sxr_partner.sv */
// Far-side model raising soft-restart requests
`timescale 1ns/1ps
module sxr_partner (
    input  wire logic core_clk_in,
    input  wire logic fire_in,
    output var logic  restart_req_out = 1'b0
);
    logic last = 1'b0;
    // One pulse per toggle, launched just after an edge
    always @(posedge core_clk_in) begin
        restart_req_out <= fire_in != last;
        last <= fire_in;
    end
endmodule // sxr_partner

/* testbench/sxr_unit_chk.sv */
// Assertion checker for the soft-restart redirect unit
`timescale 1ns/1ps
module sxr_unit_chk (
    input wire logic        core_clk_in, resetn_in, restart_req_in, deliver_ack_in,
    input wire logic        startup_msg_in, secure_boot_in, global_interrupt_flag_out,
    input wire logic        pending_out, restart_out, exc_valid_out, exc_has_err_out,
    input wire logic        exc_is_fault_out,
    input wire logic [2:0]  ctl_out,
    input wire logic [1:0]  exc_class_out,
    input wire logic [7:0]  exc_vector_out,
    input wire logic [31:0] exc_err_code_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);
    a_one_kind: assert property (!(exc_valid_out && restart_out)) else $error("two offers");
    // Decision cycle is the one before the offer rises
    a_redirect_on: assert property ($rose(exc_valid_out) |-> $past(ctl_out[1]))
        else $error("redirect w/o enable");
    a_gif_gate: assert property ($rose(exc_valid_out || restart_out) |->
        $past(global_interrupt_flag_out)) else $error("acted while flag low");
    a_restart_off: assert property ($rose(restart_out) |-> !$past(ctl_out[1]))
        else $error("restart with enable");
    a_vec_thirty: assert property (exc_valid_out |-> exc_vector_out == 8'h1e)
        else $error("bad vector");
    a_fault_kind: assert property (exc_valid_out |-> exc_is_fault_out) else $error("no fault");
    a_err_one: assert property (exc_valid_out |-> exc_has_err_out && exc_err_code_out == 32'h1)
        else $error("bad error code");
    a_contrib: assert property (exc_valid_out |-> exc_class_out == 2'h1) else $error("bad class");
    a_secure_start: assert property (startup_msg_in && secure_boot_in |=>
        !global_interrupt_flag_out && ctl_out == 3'h7) else $error("startup flags");
    a_ack_clear: assert property (exc_valid_out && deliver_ack_in && !restart_req_in |=>
        !exc_valid_out ##1 !pending_out) else $error("not cleared");
endmodule // sxr_unit_chk
bind sxr_unit sxr_unit_chk sxr_unit_chk_inst (.*);

/* testbench/sxr_unit_tb.sv */
// Self-checking bench for the soft-restart redirect unit
`timescale 1ns/1ps
module sxr_unit_tb;
    logic clk = 0, rst_n = 0, fire = 0, g_set = 0, g_clr = 0, c_wr = 0, smsg = 0, sboot = 0;
    logic ack = 0, req, flag, pend, rst_o, exv, has_e, is_f;
    logic [2:0] c_wd = 3'h0, ctl;
    logic [7:0] vec;
    logic [31:0] err;
    logic [1:0] cls;
    int fail_count = 0, compares = 0, cyc = 0;
    always #20 clk = ~clk;
    sxr_partner sxr_partner_inst (.core_clk_in(clk), .fire_in(fire), .restart_req_out(req));
    sxr_unit sxr_unit_inst (.core_clk_in(clk), .resetn_in(rst_n), .restart_req_in(req),
        .global_interrupt_flag_set_in(g_set), .global_interrupt_flag_clr_in(g_clr),
        .ctl_wr_in(c_wr), .ctl_wdata_in(c_wd),
        .startup_msg_in(smsg), .secure_boot_in(sboot), .deliver_ack_in(ack),
        .global_interrupt_flag_out(flag), .ctl_out(ctl), .pending_out(pend),
        .restart_out(rst_o), .exc_valid_out(exv), .exc_vector_out(vec),
        .exc_err_code_out(err), .exc_has_err_out(has_e), .exc_is_fault_out(is_f),
        .exc_class_out(cls));
    task automatic chk(input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n); repeat (n) @(negedge clk); endtask
    task automatic pulse(ref logic s); s = 1; tick(1); s = 0; endtask
    task automatic set_ctl(input logic [2:0] v); c_wd = v; pulse(c_wr); endtask
    // Wait for an offer, judge it, acknowledge and see it retire
    task automatic deliver(input logic redir);
        int n = 0;
        while (!(exv === 1'b1 || rst_o === 1'b1) && n < 20) begin
            tick(1);
            n++;
        end
        chk(exv, redir);
        chk(rst_o, !redir);
        if (redir) begin
            chk(vec, 8'h1e);
            chk(err, 32'h1);
            chk({has_e, is_f, cls}, 4'hd);
        end
        pulse(ack);
        chk(exv | rst_o, 0);
        tick(1);
        chk(pend, 0);
    endtask
    // Request held while the flag is low, choice made by enable at release
    task automatic sc_held;
        set_ctl(3'h2);
        pulse(g_clr);
        fire = ~fire;
        tick(8);
        chk({exv, rst_o, pend}, 3'h1);
        set_ctl(3'h0);
        pulse(g_set);
        deliver(0);
    endtask
    task automatic sc_startup;
        // Without secure mode a startup message leaves flag and control bits alone
        pulse(smsg);
        chk({flag, ctl}, 4'h8);
        sboot = 1;
        pulse(smsg);
        chk({flag, ctl}, 4'h7);
        fire = ~fire;
        tick(6);
        chk({exv, pend}, 2'h1);
        pulse(g_set);
        deliver(1);
    endtask
    task automatic close_out;
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            fail_count++;
            close_out;
        end
    end
    initial begin
        tick(10);
        rst_n = 1;
        tick(1);
        chk({flag, ctl, pend, exv, rst_o}, 7'h40); // reset values
        set_ctl(3'h2);
        fire = ~fire;
        deliver(1);
        set_ctl(3'h0);
        fire = ~fire;
        deliver(0);
        sc_held;
        sc_startup;
        close_out;
    end
endmodule // sxr_unit_tb
